// File: include/cat_consts.vh
/*
  Register map, field positions, codes and reset values of the
  acquisition trigger controller.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef CAT_CONSTS_VH
`define CAT_CONSTS_VH

// byte offsets on the avalon slave
`define CAT_OFF_CMD 5'h00
`define CAT_OFF_CFG 5'h04
`define CAT_OFF_COUNT 5'h08
`define CAT_OFF_EXPO 5'h0C
`define CAT_OFF_PERIOD 5'h10
`define CAT_OFF_STATUS 5'h14

// command bits, self clearing
`define CAT_CMD_START 0
`define CAT_CMD_STOP 1
`define CAT_CMD_SOFT 2

// configuration fields
`define CAT_CFG_MODE_LSB 0
`define CAT_CFG_TRIG_EN 4
`define CAT_CFG_SRC_LSB 8
`define CAT_CFG_ACT_RISE 12
`define CAT_CFG_PW 13
`define CAT_CFG_USER_BIT 14
`define CAT_CFG_MASK 32'h00007713

// acquisition modes
`define CAT_MODE_CONT 2'h0
`define CAT_MODE_ONE 2'h1
`define CAT_MODE_MULTI 2'h2

// trigger sources
`define CAT_SRC_SOFT 3'h0
`define CAT_SRC_USER 3'h1
`define CAT_SRC_LINK 3'h2
`define CAT_SRC_TIMER 3'h3
`define CAT_SRC_HW 3'h4

// status bits
`define CAT_ST_ACTIVE 0
`define CAT_ST_WAIT 1
`define CAT_ST_EXPO 2
`define CAT_ST_READ 3
`define CAT_ST_STOPPING 4
`define CAT_ST_FRAMES_LSB 16

// reset values
`define CAT_RST_CFG 32'h00001000
`define CAT_RST_COUNT 16'h0001
`define CAT_RST_EXPO 24'h0003E8
`define CAT_RST_PERIOD 24'h00C350

`endif

// File: design/cat_edge.v
/*
  Edge detector for one trigger signal, with an optional two-stage
  synchroniser in front.
  Assumes clk_sys and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cat_edge #(
  parameter SYNC = 1
) (
  input wire clk_sys,
  input wire resetn,
  input wire sig_in,
  output reg rise,
  output reg fall
);
  wire cur;
  reg prev;
  generate
    if (SYNC != 0)
    begin : g_sync
      reg s1;
      reg s2;
      always @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end
        else
        begin
          s1 <= sig_in;
          s2 <= s1;
        end
      end
      assign cur = s2;
    end
    else
    begin : g_direct
      assign cur = sig_in;
    end
  endgenerate
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      prev <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      prev <= cur;
      rise <= cur & ~prev;
      fall <= ~cur & prev;
    end
  end
endmodule
`default_nettype wire

// File: design/cat_count.v
/*
  Loadable down counter; done pulses value cycles after the load,
  the load cycle counted.
  Assumes the loaded value is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module cat_count #(
  parameter W = 24
) (
  input wire clk_sys,
  input wire resetn,
  input wire load,
  input wire [W-1:0] value,
  input wire run,
  output reg done
);
  reg [W-1:0] cnt;
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= {W{1'b0}};
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        // the load cycle is the first one, so a run lasts exactly value cycles
        cnt <= value - {{(W-1){1'b0}}, 1'b1};
        done <= (value == {{(W-1){1'b0}}, 1'b1});
      end
      else if (run && cnt != {W{1'b0}})
      begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        done <= (cnt == {{(W-1){1'b0}}, 1'b1});
      end
    end
  end
endmodule
`default_nettype wire

// File: design/cat_top.v
/*
  Acquisition and exposure-start trigger controller: start and stop
  commands, continuous, one-shot and counted capture, free-run pacing
  capped by the sensor's least frame period, five trigger sources,
  timed or pulse-width exposure, avalon-mm register slave.
  Assumes clk_sys at 50 MHz, sensor_ready and min_frame_period from
  logic on clk_sys, link trigger and hardware line from other domains.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cat_consts.vh"
module cat_top #(
  parameter TW = 24,
  parameter CW = 16
) (
  input wire clk_sys,
  input wire resetn,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire host_link_source,
  input wire timer_output_source,
  input wire hardware_input_source,
  input wire sensor_ready,
  input wire [TW-1:0] min_frame_period,
  output reg acq_active,
  output reg waiting_trigger,
  output reg exposure_active,
  output reg frame_start
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_EXPO = 4'b0100;
  localparam ST_READ = 4'b1000;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = be[i] ? val[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // bit of the edge vector that belongs to a source code
  function pick;
    input [3:0] v;
    input [2:0] src;
    begin
      case (src)
        `CAT_SRC_USER: pick = v[0];
        `CAT_SRC_LINK: pick = v[1];
        `CAT_SRC_TIMER: pick = v[2];
        `CAT_SRC_HW: pick = v[3];
        default: pick = 1'b0;
      endcase
    end
  endfunction

  reg [31:0] cfg;
  reg [CW-1:0] multi_frame_target_count;
  reg [TW-1:0] expo_time;
  reg [TW-1:0] frame_period;
  reg cmd_start;
  reg cmd_stop;
  reg cmd_soft;
  reg [3:0] state;
  reg [3:0] next_state;
  reg stop_pending;
  reg pw_frame;
  reg kick;
  reg [CW-1:0] frames_done;

  wire [1:0] acq_mode = cfg[`CAT_CFG_MODE_LSB +: 2];
  wire trig_en = cfg[`CAT_CFG_TRIG_EN];
  wire [2:0] src = cfg[`CAT_CFG_SRC_LSB +: 3];
  wire act_rise = cfg[`CAT_CFG_ACT_RISE];
  wire user_bit_source = cfg[`CAT_CFG_USER_BIT];
  wire wr_ok = avs_write & ~avs_waitrequest;

  // avalon slave: one wait cycle, then the access completes
  // waitrequest leaves reset high, so no access can complete early
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      avs_readdata <= 32'h00000000;
    // loaded while waitrequest is high, so the data stand at the completing edge
    else if (avs_read && avs_waitrequest)
    begin
      case (avs_address)
        `CAT_OFF_CFG: avs_readdata <= cfg;
        `CAT_OFF_COUNT: avs_readdata <= {{(32-CW){1'b0}}, multi_frame_target_count};
        `CAT_OFF_EXPO: avs_readdata <= {{(32-TW){1'b0}}, expo_time};
        `CAT_OFF_PERIOD: avs_readdata <= {{(32-TW){1'b0}}, frame_period};
        `CAT_OFF_STATUS:
        begin
          avs_readdata <= 32'h00000000;
          avs_readdata[`CAT_ST_ACTIVE] <= acq_active;
          avs_readdata[`CAT_ST_WAIT] <= waiting_trigger;
          avs_readdata[`CAT_ST_EXPO] <= exposure_active;
          avs_readdata[`CAT_ST_READ] <= state[3];
          avs_readdata[`CAT_ST_STOPPING] <= stop_pending;
          avs_readdata[`CAT_ST_FRAMES_LSB +: CW] <= frames_done;
        end
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // merged words are cut back to each register's width; upper lanes are dropped
  wire [31:0] count_word = merge({{(32-CW){1'b0}}, multi_frame_target_count},
    avs_writedata, avs_byteenable);
  wire [31:0] expo_word = merge({{(32-TW){1'b0}}, expo_time}, avs_writedata,
    avs_byteenable);
  wire [31:0] period_word = merge({{(32-TW){1'b0}}, frame_period}, avs_writedata,
    avs_byteenable);

  // settings; only one trigger type exists, so no selector is stored
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg <= `CAT_RST_CFG;
      multi_frame_target_count <= `CAT_RST_COUNT;
      expo_time <= `CAT_RST_EXPO;
      frame_period <= `CAT_RST_PERIOD;
    end
    else if (wr_ok)
    begin
      case (avs_address)
        `CAT_OFF_CFG: cfg <= merge(cfg, avs_writedata, avs_byteenable)
          & `CAT_CFG_MASK;
        `CAT_OFF_COUNT: multi_frame_target_count <= count_word[CW-1:0];
        `CAT_OFF_EXPO: expo_time <= expo_word[TW-1:0];
        `CAT_OFF_PERIOD: frame_period <= period_word[TW-1:0];
        default: ;
      endcase
    end
  end

  // command pulses live for exactly one cycle
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_start <= 1'b0;
      cmd_stop <= 1'b0;
      cmd_soft <= 1'b0;
    end
    else
    begin
      cmd_start <= wr_ok && avs_address == `CAT_OFF_CMD && avs_byteenable[0]
        && avs_writedata[`CAT_CMD_START];
      cmd_stop <= wr_ok && avs_address == `CAT_OFF_CMD && avs_byteenable[0]
        && avs_writedata[`CAT_CMD_STOP];
      cmd_soft <= wr_ok && avs_address == `CAT_OFF_CMD && avs_byteenable[0]
        && avs_writedata[`CAT_CMD_SOFT];
    end
  end

  // edge detection; link and hardware line come from other domains
  wire [3:0] raw = {hardware_input_source, timer_output_source,
    host_link_source, user_bit_source};
  wire [3:0] rise_v;
  wire [3:0] fall_v;
  // the user bit is written on this clock, so it skips the synchroniser
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_edge
      cat_edge #(
        .SYNC((gi == 1 || gi == 3) ? 1 : 0)
      ) u_edge (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sig_in(raw[gi]),
        .rise(rise_v[gi]),
        .fall(fall_v[gi])
      );
    end
  endgenerate

  wire ext_lead = (src == `CAT_SRC_SOFT) ? cmd_soft
    : (act_rise ? pick(rise_v, src) : pick(fall_v, src));
  wire ext_trail = act_rise ? pick(fall_v, src) : pick(rise_v, src);

  // free-run pacing: the least frame period caps the rate
  wire [TW-1:0] capped = (frame_period < min_frame_period)
    ? min_frame_period : frame_period;
  // a zero period or exposure would wrap the counter to its largest count, so it runs as one
  wire [TW-1:0] period_eff = (capped == {TW{1'b0}})
    ? {{(TW-1){1'b0}}, 1'b1} : capped;
  wire free_done;
  wire free_tick = kick | free_done;
  cat_count #(
    .W(TW)
  ) u_free (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(free_tick),
    .value(period_eff),
    .run(acq_active & ~trig_en),
    .done(free_done)
  );

  // a free-run tick that meets a busy frame is simply lost
  wire trig = trig_en ? ext_lead : free_tick;
  // software source never uses pulse width
  wire pw_sel = trig_en && cfg[`CAT_CFG_PW]
    && src != `CAT_SRC_SOFT;
  wire [TW-1:0] expo_eff = (expo_time == {TW{1'b0}})
    ? {{(TW-1){1'b0}}, 1'b1} : expo_time;
  // stop wins over a trigger in the same cycle; that trigger is dropped
  wire accept = state[1] && trig && !cmd_stop;
  wire expo_done;
  cat_count #(
    .W(TW)
  ) u_expo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(accept),
    .value(expo_eff),
    .run(state[2] & ~pw_frame),
    .done(expo_done)
  );

  // a target of zero acts as one, since the first frame already meets it
  wire [CW-1:0] frames_next = frames_done + {{(CW-1){1'b0}}, 1'b1};
  wire last_frame = (acq_mode == `CAT_MODE_ONE)
    || (acq_mode == `CAT_MODE_MULTI
    && frames_next >= multi_frame_target_count);
  // pulse-width frames end on the opposite edge of the same source
  wire expo_end = pw_frame ? ext_trail : expo_done;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cmd_start)
          next_state = ST_WAIT;
      ST_WAIT:
        if (cmd_stop)
          next_state = ST_IDLE;
        else if (accept)
          next_state = ST_EXPO;
      ST_EXPO:
        if (expo_end)
          next_state = ST_READ;
      // a frame in readout always finishes before the block goes idle
      ST_READ:
        if (sensor_ready)
          next_state = (stop_pending || cmd_stop) ? ST_IDLE : ST_WAIT;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      acq_active <= 1'b0;
      waiting_trigger <= 1'b0;
      exposure_active <= 1'b0;
      frame_start <= 1'b0;
      stop_pending <= 1'b0;
      pw_frame <= 1'b0;
      kick <= 1'b0;
      frames_done <= {CW{1'b0}};
    end
    else
    begin
      state <= next_state;
      waiting_trigger <= (next_state == ST_WAIT);
      exposure_active <= (next_state == ST_EXPO);
      acq_active <= (next_state != ST_IDLE);
      frame_start <= accept;
      kick <= cmd_start && state[0] && !trig_en;
      // exposure kind is latched per frame, so a mid-frame change cannot cut it
      if (accept)
        pw_frame <= pw_sel;
      // start while active is ignored, so a running count is never reset
      if (state[0] && cmd_start)
      begin
        frames_done <= {CW{1'b0}};
        stop_pending <= 1'b0;
      end
      else if (accept)
      begin
        frames_done <= frames_next;
        // set wins: the last accepted frame always arms the stop
        stop_pending <= stop_pending | last_frame;
      end
      else if (cmd_stop && (state[2] || state[3]) && next_state != ST_IDLE)
        stop_pending <= 1'b1;
      else if (next_state == ST_IDLE)
        stop_pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/cat_props.sv
/*
  Checker on the cat_top ports, bound into every cat_top instance.
  Assumes one clock clk_sys and resetn active low.
*/
`timescale 1ns/1ps
`default_nettype none
module cat_props #(
  parameter TW = 24,
  parameter CW = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic host_link_source,
  input wire logic timer_output_source,
  input wire logic hardware_input_source,
  input wire logic sensor_ready,
  input wire logic [TW-1:0] min_frame_period,
  input wire logic acq_active,
  input wire logic waiting_trigger,
  input wire logic exposure_active,
  input wire logic frame_start
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  bus_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  accept_wait_a:
    assert property (frame_start |-> $past(waiting_trigger))
    else $error("frame started while not waiting");
  frame_armed_a:
    assert property (frame_start |-> $past(acq_active))
    else $error("frame started while idle");
  expo_launch_a:
    assert property (frame_start |-> exposure_active ##1 !frame_start)
    else $error("frame start without exposure");
  expo_cause_a:
    assert property ($rose(exposure_active) |-> frame_start)
    else $error("exposure without frame start");
  wait_state_a:
    assert property (waiting_trigger |-> acq_active && !exposure_active)
    else $error("waiting while idle or exposing");
  stop_finish_a:
    assert property ($fell(acq_active) |-> !exposure_active)
    else $error("stopped during exposure");
endmodule
bind cat_top cat_props #(.TW(TW), .CW(CW)) u_cat_props (
  .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .host_link_source(host_link_source),
  .timer_output_source(timer_output_source),
  .hardware_input_source(hardware_input_source), .sensor_ready(sensor_ready),
  .min_frame_period(min_frame_period), .acq_active(acq_active),
  .waiting_trigger(waiting_trigger), .exposure_active(exposure_active),
  .frame_start(frame_start));
`default_nettype wire

// File: verif/cat_far.sv
/*
  Far side: trigger lines of grabber, timer and hardware input, and sensor.
  Assumes fire is a one-cycle request from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module cat_far #(
  parameter RD = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fire,
  input wire logic [1:0] sel,
  input wire logic [7:0] width,
  input wire logic exposure_active,
  output logic host_link_source,
  output logic timer_output_source,
  output logic hardware_input_source,
  output logic sensor_ready
);
  logic [7:0] hi;
  logic [3:0] rd;
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hi <= 8'h00;
      rd <= 4'h0;
    end
    else
    begin
      hi <= fire ? width : hi - {7'h00, hi != 8'h00};
      rd <= exposure_active ? 4'(RD) : rd - {3'h0, rd != 4'h0};
    end
  end
  // lines idle low; one pulse per request, spacing kept by the bench
  assign host_link_source = hi != 8'h00 && sel == 2'h0;
  assign timer_output_source = hi != 8'h00 && sel == 2'h1;
  assign hardware_input_source = hi != 8'h00 && sel == 2'h2;
  // readout blocks the next exposure for RD cycles
  assign sensor_ready = !exposure_active && rd == 4'h0;
endmodule
`default_nettype wire

// File: verif/tb_camera_acquisition_trigger_control.sv
/*
  Bench for cat_top: avalon tasks, far-side model, frame counters.
  Assumes cat_consts.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cat_consts.vh"
module tb_camera_acquisition_trigger_control;
  logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest, fire;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [23:0] min_frame_period;
  logic acq_active, waiting_trigger, exposure_active, frame_start;
  logic lnk, tmr, hw, srdy;
  logic [1:0] sel;
  logic [7:0] width;
  logic [2:0] s;
  int failures = 0, checked = 0, frames = 0, elen = 0, gap = 0, lastgap = 0, cyc = 0, f;
  cat_top DUT (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .host_link_source(lnk), .timer_output_source(tmr), .hardware_input_source(hw),
    .sensor_ready(srdy), .min_frame_period(min_frame_period), .acq_active(acq_active),
    .waiting_trigger(waiting_trigger), .exposure_active(exposure_active),
    .frame_start(frame_start));
  cat_far far (.clk_sys(clk_sys), .resetn(resetn), .fire(fire), .sel(sel), .width(width),
    .exposure_active(exposure_active), .host_link_source(lnk), .timer_output_source(tmr),
    .hardware_input_source(hw), .sensor_ready(srdy));
  initial
  begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    frames <= frames + (frame_start === 1'b1);
    elen <= frame_start === 1'b1 ? 1 : elen + (exposure_active === 1'b1);
    gap <= frame_start === 1'b1 ? 1 : gap + 1;
    if (frame_start === 1'b1)
      lastgap <= gap;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end
  task summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low; read data taken there
  task acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    if (!wr)
      chk(avs_readdata, d);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task pulse(input logic [1:0] l, input logic [7:0] w);
    @(posedge clk_sys);
    fire <= 1'b1;
    sel <= l;
    width <= w;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial
  begin
    {resetn, avs_read, avs_write, fire, avs_address, avs_writedata, sel, width} = 0;
    min_frame_period = 24'h00000A;
    idle(8);
    resetn <= 1'b1;
    acc(0, `CAT_OFF_CFG, `CAT_RST_CFG);
    acc(0, `CAT_OFF_COUNT, 32'h00000001);
    acc(0, `CAT_OFF_EXPO, 32'h000003E8);
    acc(0, `CAT_OFF_PERIOD, 32'h0000C350);
    acc(0, 5'h18, 32'h00000000);
    acc(1, `CAT_OFF_EXPO, 32'h00000008);
    acc(1, `CAT_OFF_CFG, 32'h00001010);
    acc(1, `CAT_OFF_CMD, 32'h00000004);
    idle(40);
    chk(frames, 0);
    acc(1, `CAT_OFF_CMD, 32'h00000001);
    acc(1, `CAT_OFF_CMD, 32'h00000004);
    idle(40);
    chk(frames, 1);
    chk(elen, 8);
    acc(1, `CAT_OFF_CFG, 32'h00003010);
    acc(1, `CAT_OFF_CMD, 32'h00000004);
    acc(1, `CAT_OFF_CMD, 32'h00000004);
    idle(40);
    chk(frames, 2);
    chk(elen, 8);
    acc(1, `CAT_OFF_CMD, 32'h00000002);
    acc(1, `CAT_OFF_CMD, 32'h00000004);
    idle(40);
    chk(frames, 2);
    $display("software trigger tests done");
    for (s = 3'h1; s <= 3'h4; s++)
    begin
      acc(1, `CAT_OFF_CFG, 32'h00001010 | {21'h0, s, 8'h00});
      acc(1, `CAT_OFF_CMD, 32'h00000001);
      if (s == 3'h1)
        acc(1, `CAT_OFF_CFG, 32'h00005110);
      else
        pulse(s[1:0] - 2'h2, 8'h06);
      idle(40);
      chk(frames, 2 + s);
      acc(1, `CAT_OFF_CMD, 32'h00000002);
    end
    acc(1, `CAT_OFF_CFG, 32'h00003410);
    acc(1, `CAT_OFF_CMD, 32'h00000001);
    pulse(2'h2, 8'h1E);
    idle(60);
    chk(elen >= 29 && elen <= 31, 1);
    acc(1, `CAT_OFF_CFG, 32'h00000410);
    pulse(2'h2, 8'h14);
    idle(10);
    chk(frames, 7);
    idle(40);
    chk(frames, 8);
    acc(1, `CAT_OFF_CMD, 32'h00000002);
    $display("trigger source tests done");
    acc(1, `CAT_OFF_PERIOD, 32'h00000064);
    acc(1, `CAT_OFF_CFG, 32'h00001001);
    acc(1, `CAT_OFF_CMD, 32'h00000001);
    idle(400);
    chk(frames, 9);
    chk(acq_active, 0);
    acc(1, `CAT_OFF_COUNT, 32'h00000003);
    acc(1, `CAT_OFF_CFG, 32'h00001002);
    acc(1, `CAT_OFF_CMD, 32'h00000001);
    idle(600);
    chk(frames, 12);
    chk(acq_active, 0);
    acc(1, `CAT_OFF_CFG, 32'h00001000);
    acc(1, `CAT_OFF_CMD, 32'h00000001);
    idle(350);
    chk(lastgap, 100);
    min_frame_period <= 24'h00012C;
    idle(700);
    chk(lastgap, 300);
    acc(1, `CAT_OFF_EXPO, 32'h000000C8);
    // skip a frame that may have been accepted with the old exposure
    repeat (2)
    begin
      @(posedge clk_sys);
      while (frame_start !== 1'b1)
        @(posedge clk_sys);
    end
    f = frames + 1;
    acc(1, `CAT_OFF_CMD, 32'h00000002);
    idle(600);
    chk(elen, 200);
    chk(frames, f);
    chk(acq_active, 0);
    $display("free run tests done");
    summarize();
  end
endmodule
`default_nettype wire
